// File: inc/nvc_regs.vh
/*
 * Constants for the host-side controller of a byte-wide nonvolatile SRAM:
 * command addresses, pin timing counts and operation codes.
 * Assumes a 200 MHz system clock; each time is rounded up to whole cycles.
 */
`ifndef NVC_REGS_VH
`define NVC_REGS_VH

`define NVC_CLK_MHZ        200
// ----------------------------------------------------------------------------
// Timing in ns, us and ms, and the matching cycle counts
// ----------------------------------------------------------------------------
`define NVC_T_CYCLE_NS     35
`define NVC_T_CYCLE_CYC    ((`NVC_T_CYCLE_NS * `NVC_CLK_MHZ + 999) / 1000)
`define NVC_T_PULSE_NS     25
`define NVC_T_PULSE_CYC    ((`NVC_T_PULSE_NS * `NVC_CLK_MHZ + 999) / 1000)
`define NVC_T_ACCESS_NS    35
`define NVC_T_ACCESS_CYC   ((`NVC_T_ACCESS_NS * `NVC_CLK_MHZ + 999) / 1000)
`define NVC_T_HSBPULSE_NS  15
`define NVC_T_HSBPULSE_CYC ((`NVC_T_HSBPULSE_NS * `NVC_CLK_MHZ + 999) / 1000)
`define NVC_T_STORE_MS     8
`define NVC_T_STORE_CYC    (`NVC_T_STORE_MS * `NVC_CLK_MHZ * 1000)
`define NVC_T_RECALL_US    200
`define NVC_T_RECALL_CYC   (`NVC_T_RECALL_US * `NVC_CLK_MHZ)
`define NVC_T_SOFTSEQ_US   100
`define NVC_T_SOFTSEQ_CYC  (`NVC_T_SOFTSEQ_US * `NVC_CLK_MHZ)
`define NVC_T_RESUME_US    5
`define NVC_T_RESUME_CYC   (`NVC_T_RESUME_US * `NVC_CLK_MHZ)
`define NVC_T_PWRUP_MS     20
`define NVC_T_PWRUP_CYC    (`NVC_T_PWRUP_MS * `NVC_CLK_MHZ * 1000)

// ----------------------------------------------------------------------------
// Command sequence addresses (low 14 bits decoded) and host operations
// ----------------------------------------------------------------------------
`define NVC_SEQ0           17'h04E38
`define NVC_SEQ1           17'h0B1C7
`define NVC_SEQ2           17'h083E0
`define NVC_SEQ3           17'h07C1F
`define NVC_SEQ4           17'h0703F
`define NVC_ADR_STORE      17'h08FC0
`define NVC_ADR_RECALL     17'h04C63
`define NVC_ADR_AUTO_OFF   17'h08B45
`define NVC_ADR_AUTO_ON    17'h04B46

`define NVC_OP_READ        3'h0
`define NVC_OP_WRITE       3'h1
`define NVC_OP_STORE       3'h2
`define NVC_OP_RECALL      3'h3
`define NVC_OP_AUTO_OFF    3'h4
`define NVC_OP_AUTO_ON     3'h5
`define NVC_OP_HW_STORE    3'h6

`endif

// File: hdl/nvc_cnt.v
/*
 * Down-counter used for every wait of the controller.
 * Assumes the caller loads a nonzero count and watches o_done.
 */
`timescale 1ns/1ps
`default_nettype none
module nvc_cnt (
    input  wire        i_clk_sys,
    input  wire        i_reset_n,
    input  wire        i_ce,
    input  wire        i_load,
    input  wire [31:0] i_value,
    output wire        o_done
);
    reg [31:0] cnt_r;

    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_r <= 32'h00000000;
        end else if (i_ce) begin
            if (i_load) begin
                cnt_r <= i_value;
            end else if (cnt_r != 32'h00000000) begin
                cnt_r <= cnt_r - 32'h00000001;
            end
        end
    end

    assign o_done = (cnt_r == 32'h00000000);
endmodule
`default_nettype wire

// File: hdl/nvc_ctrl.v
/*
 * Host-side controller for an asynchronous byte-wide nonvolatile SRAM.
 * Runs reads, writes, software commands and pin-initiated stores on the
 * device's pins. Assumes all pin inputs are synchronous to i_clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nvc_regs.vh"
module nvc_ctrl #(
    parameter [31:0] P_STORE_CYC  = `NVC_T_STORE_CYC,
    parameter [31:0] P_RECALL_CYC = `NVC_T_RECALL_CYC,
    parameter [31:0] P_SEQ_CYC    = `NVC_T_SOFTSEQ_CYC,
    parameter [31:0] P_PWRUP_CYC  = `NVC_T_PWRUP_CYC
) (
    input  wire        i_clk_sys,
    input  wire        i_reset_n,
    input  wire        i_ce,
    input  wire        i_req_valid,
    input  wire [2:0]  i_req_op,
    input  wire [16:0] i_req_addr,
    input  wire [7:0]  i_req_wdata,
    output reg         o_req_ready,
    output reg         o_rsp_valid,
    output reg  [7:0]  o_rsp_rdata,
    output reg         o_autostore_on,
    output reg  [16:0] o_mem_addr,
    output reg         o_mem_chip_sel_n,
    output reg         o_mem_wr_n,
    output reg         o_mem_out_en_n,
    input  wire [7:0]  i_mem_dq,
    output reg  [7:0]  o_mem_dq,
    output reg         o_mem_dq_oe,
    input  wire        i_store_busy_n,
    output reg         o_store_busy_n,
    output reg         o_store_busy_oe
);
    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [3:0] S_PWRUP  = 4'h0;
    localparam [3:0] S_IDLE   = 4'h1;
    localparam [3:0] S_SETUP  = 4'h2;
    localparam [3:0] S_STROBE = 4'h3;
    localparam [3:0] S_RECOV  = 4'h4;
    localparam [3:0] S_NVWAIT = 4'h5;
    localparam [3:0] S_BUSYW  = 4'h6;
    localparam [3:0] S_RESUME = 4'h7;
    localparam [3:0] S_HSBPUL = 4'h8;

    localparam [31:0] C_PULSE  = `NVC_T_PULSE_CYC;
    localparam [31:0] C_RECOV  = `NVC_T_CYCLE_CYC - `NVC_T_PULSE_CYC + 1;
    localparam [31:0] C_HSB    = `NVC_T_HSBPULSE_CYC;
    localparam [31:0] C_RESUME = `NVC_T_RESUME_CYC;

    reg  [3:0]  state_r;
    reg  [2:0]  op_r;
    reg  [2:0]  step_r;
    reg  [16:0] last_addr_r;
    reg         is_write_r;
    reg         pwr_loaded_r;
    reg         load;
    reg  [31:0] load_val;
    wire        done;

    nvc_cnt u_cnt (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_load    (load),
        .i_value   (load_val),
        .o_done    (done)
    );

    // Address of the current read within a command sequence.
    function [16:0] seq_addr;
        input [2:0] step;
        input [2:0] op;
        begin
            case (step)
                3'h0:    seq_addr = `NVC_SEQ0;
                3'h1:    seq_addr = `NVC_SEQ1;
                3'h2:    seq_addr = `NVC_SEQ2;
                3'h3:    seq_addr = `NVC_SEQ3;
                3'h4:    seq_addr = `NVC_SEQ4;
                default: begin
                    case (op)
                        `NVC_OP_STORE:    seq_addr = `NVC_ADR_STORE;
                        `NVC_OP_RECALL:   seq_addr = `NVC_ADR_RECALL;
                        `NVC_OP_AUTO_OFF: seq_addr = `NVC_ADR_AUTO_OFF;
                        default:          seq_addr = `NVC_ADR_AUTO_ON;
                    endcase
                end
            endcase
        end
    endfunction

    wire is_seq = (op_r == `NVC_OP_STORE) || (op_r == `NVC_OP_RECALL) ||
                  (op_r == `NVC_OP_AUTO_OFF) || (op_r == `NVC_OP_AUTO_ON);

    // Load the shared counter on state entry.
    always @* begin
        load = 1'b0;
        load_val = 32'h00000000;
        case (state_r)
            S_PWRUP: begin
                // Loaded once, on the first enabled edge after reset.
                if (!pwr_loaded_r) begin
                    load = 1'b1;
                    load_val = P_PWRUP_CYC;
                end
            end
            S_IDLE: begin
                if (i_req_valid && o_req_ready) begin
                    load = 1'b1;
                    load_val = 32'h00000001;
                end
            end
            S_SETUP: begin
                load = 1'b1;
                load_val = (op_r == `NVC_OP_HW_STORE) ? C_HSB : C_PULSE;
            end
            S_STROBE: begin
                if (done) begin
                    load = 1'b1;
                    load_val = C_RECOV;
                end
            end
            S_RECOV: begin
                if (done && is_seq && step_r == 3'h5) begin
                    load = 1'b1;
                    load_val = (op_r == `NVC_OP_STORE)  ? P_SEQ_CYC + P_STORE_CYC :
                               (op_r == `NVC_OP_RECALL) ? P_SEQ_CYC + P_RECALL_CYC :
                               P_SEQ_CYC;
                end
            end
            S_HSBPUL: begin
                if (done) begin
                    load = 1'b1;
                    load_val = P_STORE_CYC;
                end
            end
            S_BUSYW: begin
                if (done || i_store_busy_n) begin
                    load = 1'b1;
                    load_val = C_RESUME;
                end
            end
            S_NVWAIT: begin
                if (done) begin
                    load = 1'b1;
                    load_val = C_RESUME;
                end
            end
            default: begin
                load = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r          <= S_PWRUP;
            op_r             <= `NVC_OP_READ;
            step_r           <= 3'h0;
            last_addr_r      <= 17'h00000;
            is_write_r       <= 1'b0;
            o_req_ready      <= 1'b0;
            o_rsp_valid      <= 1'b0;
            o_rsp_rdata      <= 8'h00;
            o_autostore_on   <= 1'b1;
            o_mem_addr       <= 17'h00000;
            o_mem_chip_sel_n <= 1'b1;
            o_mem_wr_n       <= 1'b1;
            o_mem_out_en_n   <= 1'b1;
            o_mem_dq         <= 8'h00;
            o_mem_dq_oe      <= 1'b0;
            o_store_busy_n   <= 1'b1;
            o_store_busy_oe  <= 1'b0;
        end else if (i_ce) begin
            o_rsp_valid <= 1'b0;
            case (state_r)
                S_PWRUP: begin
                    // Wait out the worst-case power-up recall before any access.
                    if (pwr_loaded_r && done && i_store_busy_n) begin
                        state_r     <= S_IDLE;
                        o_req_ready <= 1'b1;
                    end
                end
                S_IDLE: begin
                    if (i_req_valid && o_req_ready) begin
                        o_req_ready <= 1'b0;
                        op_r        <= i_req_op;
                        step_r      <= 3'h0;
                        last_addr_r <= i_req_addr;
                        o_mem_dq    <= i_req_wdata;
                        is_write_r  <= (i_req_op == `NVC_OP_WRITE);
                        state_r     <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    // Address is driven on the same edge that pulls chip select and the strobe low.
                    state_r <= S_STROBE;
                    if (op_r == `NVC_OP_HW_STORE) begin
                        o_store_busy_n  <= 1'b0;
                        o_store_busy_oe <= 1'b1;
                        state_r         <= S_HSBPUL;
                    end else begin
                        o_mem_addr <= is_seq ? seq_addr(step_r, op_r) : last_addr_r;
                        o_mem_chip_sel_n <= 1'b0;
                        o_mem_wr_n  <= ~is_write_r;
                        o_mem_out_en_n <= is_write_r;
                        o_mem_dq_oe <= is_write_r;
                    end
                end
                S_STROBE: begin
                    if (done) begin
                        o_rsp_rdata      <= i_mem_dq;
                        o_mem_chip_sel_n <= 1'b1;
                        o_mem_wr_n       <= 1'b1;
                        o_mem_out_en_n   <= 1'b1;
                        o_mem_dq_oe      <= 1'b0;
                        state_r          <= S_RECOV;
                    end
                end
                S_RECOV: begin
                    if (done) begin
                        if (is_seq && step_r != 3'h5) begin
                            step_r  <= step_r + 3'h1;
                            state_r <= S_SETUP;
                        end else if (is_seq) begin
                            state_r <= S_NVWAIT;
                            if (op_r == `NVC_OP_AUTO_OFF) o_autostore_on <= 1'b0;
                            if (op_r == `NVC_OP_AUTO_ON)  o_autostore_on <= 1'b1;
                        end else begin
                            o_rsp_valid <= 1'b1;
                            o_req_ready <= 1'b1;
                            state_r     <= S_IDLE;
                        end
                    end
                end
                S_HSBPUL: begin
                    if (done) begin
                        // Release the pin; the device holds it low while it stores.
                        o_store_busy_n  <= 1'b1;
                        o_store_busy_oe <= 1'b0;
                        state_r         <= S_BUSYW;
                    end
                end
                S_BUSYW: begin
                    // A store with nothing to save never pulls the pin low.
                    if (done || i_store_busy_n) begin
                        state_r <= S_RESUME;
                    end
                end
                S_NVWAIT: begin
                    if (done) begin
                        state_r <= S_RESUME;
                    end
                end
                S_RESUME: begin
                    // Hold off access until outputs are surely back on.
                    if (done && i_store_busy_n) begin
                        o_rsp_valid <= 1'b1;
                        o_req_ready <= 1'b1;
                        state_r     <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Marks that the power-up wait has been loaded, so the counter starts it only once.
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pwr_loaded_r <= 1'b0;
        end else if (i_ce) begin
            pwr_loaded_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: verification/nvc_ctrl_properties.sv
/*
 * Pin-level assertions for the nonvolatile SRAM host controller.
 * Assumes it is bound to nvc_ctrl and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module nvc_ctrl_properties (
    input wire logic        i_clk_sys,
    input wire logic        i_reset_n,
    input wire logic        i_ce,
    input wire logic        i_req_valid,
    input wire logic [2:0]  i_req_op,
    input wire logic        o_req_ready,
    input wire logic        o_rsp_valid,
    input wire logic [16:0] o_mem_addr,
    input wire logic        o_mem_chip_sel_n,
    input wire logic        o_mem_wr_n,
    input wire logic        o_mem_out_en_n,
    input wire logic        o_mem_dq_oe,
    input wire logic        i_store_busy_n,
    input wire logic        o_store_busy_n,
    input wire logic        o_store_busy_oe
);
    // ------------------------------------------------------------------
    // Pin discipline
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    wire take = i_ce && i_req_valid && o_req_ready;

    a_read_wr_high: assert property (!o_mem_out_en_n && !o_mem_chip_sel_n |-> o_mem_wr_n)
        else $error("write strobe low in a read");
    a_busy_left_high: assert property (!o_mem_chip_sel_n |-> !o_store_busy_oe)
        else $error("store pin driven during an access");
    a_addr_move_safe: assert property ($changed(o_mem_addr) |->
        $past(o_mem_chip_sel_n) || $past(o_mem_wr_n)) else $error("address moved in a write");
    a_read_pulse_width: assert property ($fell(o_mem_out_en_n) |->
        (!o_mem_out_en_n && !o_mem_chip_sel_n)[*5]) else $error("read strobe too short");
    a_write_pulse_width: assert property ($fell(o_mem_wr_n) |->
        (!o_mem_wr_n && !o_mem_chip_sel_n && o_mem_dq_oe)[*5]) else $error("write too short");
    a_pin_store_pulse: assert property ($rose(o_store_busy_oe) |->
        (o_store_busy_oe && !o_store_busy_n)[*3]) else $error("store pulse too short");
    a_hold_while_busy: assert property (!i_store_busy_n && o_mem_chip_sel_n |=>
        o_mem_chip_sel_n) else $error("access started while busy");
    a_one_cycle_rsp: assert property (o_rsp_valid |=> !o_rsp_valid)
        else $error("response longer than one cycle");
    a_read_latency: assert property (take && i_req_op == 3'h0 |-> ##[6:14] o_rsp_valid)
        else $error("read response late");
endmodule
bind nvc_ctrl nvc_ctrl_properties nvc_ctrl_properties_i (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_req_valid(i_req_valid),
    .i_req_op(i_req_op), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_mem_addr(o_mem_addr), .o_mem_chip_sel_n(o_mem_chip_sel_n), .o_mem_wr_n(o_mem_wr_n),
    .o_mem_out_en_n(o_mem_out_en_n), .o_mem_dq_oe(o_mem_dq_oe),
    .i_store_busy_n(i_store_busy_n), .o_store_busy_n(o_store_busy_n),
    .o_store_busy_oe(o_store_busy_oe));
`default_nettype wire

// File: verification/nvc_dev_model.sv
/*
 * Behavioural model of the byte-wide nonvolatile SRAM on the host pins.
 * Assumes pins change just after i_clk_sys edges; the bench resolves wires.
 */
`timescale 1ns/1ps
`default_nettype none
module nvc_dev_model #(
    parameter int STORE_CYC  = 30,
    parameter int RECALL_CYC = 15,
    parameter int PWRUP_CYC  = 40
) (
    input  wire logic        i_clk_sys,
    input  wire logic [16:0] i_addr,
    input  wire logic        i_chip_sel_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_out_en_n,
    input  wire logic [7:0]  i_dq,
    input  wire logic        i_store_busy_n,
    output logic [7:0]       o_dq,
    output logic             o_dq_oe,
    output logic             o_busy_low,
    output logic             o_busy_high,
    output logic             o_auto_on,
    output int               o_stores
);
    // ------------------------------------------------------------------
    // Array, command decoder and nonvolatile timing
    // ------------------------------------------------------------------
    localparam logic [16:0] SEQ [5] = '{17'h04E38, 17'h0B1C7, 17'h083E0, 17'h07C1F, 17'h0703F};
    logic [7:0] sram [int];
    logic [7:0] nv [int];
    int         busy_cnt = PWRUP_CYC;
    int         hold_cnt = 0;
    int         step = 0;
    logic       written = 1'b0;
    logic       storing = 1'b0;
    logic       wlo = 1'b0;
    logic       cs_q = 1'b1;
    logic       oe_q = 1'b1;
    logic       bsy_q = 1'b1;
    wire        rd_go = !i_chip_sel_n && !i_out_en_n && i_wr_n && (cs_q || oe_q);
    // A select that opens with the write strobe low never drives the bus.
    wire        wlo_now = (cs_q && !i_chip_sel_n) ? !i_wr_n : wlo;

    initial begin
        o_busy_low = 1'b1;
        o_auto_on = 1'b1;
        o_stores = 0;
    end
    always_comb begin
        o_dq_oe = !i_chip_sel_n && i_wr_n && !i_out_en_n && !wlo_now && busy_cnt == 0;
        o_dq = sram.exists(i_addr) ? sram[i_addr] : 8'h00;
    end

    task start_store();
        nv = sram;
        storing <= 1'b1;
        o_busy_low <= 1'b1;
        busy_cnt <= STORE_CYC;
        written <= 1'b0;
        o_stores <= o_stores + 1;
    endtask

    always @(posedge i_clk_sys) begin
        cs_q <= i_chip_sel_n;
        oe_q <= i_out_en_n;
        bsy_q <= i_store_busy_n;
        wlo <= wlo_now;
        o_busy_high <= hold_cnt != 0;
        if (hold_cnt != 0)
            hold_cnt <= hold_cnt - 1;
        if (busy_cnt != 0) begin
            busy_cnt <= busy_cnt - 1;
            // A write under way when a store starts still lands for 35 ns, 7 cycles.
            if (storing && busy_cnt > STORE_CYC - 7 && !i_chip_sel_n && !i_wr_n)
                sram[i_addr] = i_dq;
            if (busy_cnt == 1 && o_busy_low) begin
                storing <= 1'b0;
                o_busy_low <= 1'b0;
                hold_cnt <= 20;
            end
        end else if (bsy_q && !i_store_busy_n) begin
            if (written)
                start_store();
        end else if (!i_chip_sel_n && !i_wr_n) begin
            sram[i_addr] = i_dq;
            written <= 1'b1;
            step <= 0;
        end else if (rd_go) begin
            step <= (i_addr[13:0] == SEQ[0][13:0]) ? 1 : 0;
            if (step < 5 && i_addr[13:0] == SEQ[step][13:0])
                step <= step + 1;
            else if (step == 5) begin
                case (i_addr[13:0])
                    14'h0FC0: start_store();
                    14'h0C63: begin
                        sram = nv;
                        written <= 1'b0;
                        busy_cnt <= RECALL_CYC;
                    end
                    14'h0B45: o_auto_on <= 1'b0;
                    14'h0B46: o_auto_on <= 1'b1;
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/nvc_ctrl_tb.sv
/*
 * Self-checking bench for the nonvolatile SRAM host controller.
 * Assumes nvc_dev_model stands for the memory; this module resolves the wires.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nvc_regs.vh"
module nvc_ctrl_tb;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        req_valid = 1'b0;
    logic [2:0]  req_op = 3'h0;
    logic [16:0] req_addr = 17'h00000;
    logic [7:0]  req_wdata = 8'h00;
    logic [7:0]  dq_last = 8'h00;
    logic [7:0]  rd;
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          bhi_run = 0;
    int          bhi_max = 0;
    int          d_stores;
    wire         ready, rsp, auto_on, cs_n, wr_n, oe_n, h_oe, h_bn, h_boe;
    wire         d_oe, d_blo, d_bhi, d_auto;
    wire  [7:0]  rdata, h_dq, d_dq;
    wire  [16:0] mem_addr;
    // An undriven data bus shows the inverse of its last level, not a held value.
    wire  [7:0]  dq_w = h_oe ? h_dq : (d_oe ? d_dq : ~dq_last);
    wire         busy_w = !((h_boe && !h_bn) || d_blo);

    initial forever #2.5 clk_sys = ~clk_sys;

    nvc_ctrl #(.P_STORE_CYC(20), .P_RECALL_CYC(20), .P_SEQ_CYC(20), .P_PWRUP_CYC(20)) nvc_ctrl_i (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_ce(1'b1), .i_req_valid(req_valid),
        .i_req_op(req_op), .i_req_addr(req_addr), .i_req_wdata(req_wdata), .o_req_ready(ready),
        .o_rsp_valid(rsp), .o_rsp_rdata(rdata), .o_autostore_on(auto_on), .o_mem_addr(mem_addr),
        .o_mem_chip_sel_n(cs_n), .o_mem_wr_n(wr_n), .o_mem_out_en_n(oe_n), .i_mem_dq(dq_w),
        .o_mem_dq(h_dq), .o_mem_dq_oe(h_oe), .i_store_busy_n(busy_w), .o_store_busy_n(h_bn),
        .o_store_busy_oe(h_boe));
    nvc_dev_model nvc_dev_model_i (
        .i_clk_sys(clk_sys), .i_addr(mem_addr), .i_chip_sel_n(cs_n), .i_wr_n(wr_n),
        .i_out_en_n(oe_n), .i_dq(dq_w), .i_store_busy_n(busy_w), .o_dq(d_dq), .o_dq_oe(d_oe),
        .o_busy_low(d_blo), .o_busy_high(d_bhi), .o_auto_on(d_auto), .o_stores(d_stores));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        dq_last <= dq_w;
        cycles <= cycles + 1;
        bhi_run <= d_bhi ? bhi_run + 1 : 0;
        if (bhi_run > bhi_max)
            bhi_max <= bhi_run;
        if (cycles == 20000) begin
            fails++;
            $display("Error: run length expected under 20000 seen 20000");
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error: %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Holds the request until ready is seen, then waits for the response pulse.
    task automatic do_op(input logic [2:0] o, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_op <= o;
        req_addr <= a;
        req_wdata <= d;
        do begin @(negedge clk_sys); n++; end while (ready !== 1'b1 && n < 4000);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        while (rsp !== 1'b1 && n < 4000) begin @(negedge clk_sys); n++; end
        rd = rdata;
        check("response within bound", n < 4000, 1'b1);
    endtask

    task automatic test_powerup();
        int n;
        n = 0;
        repeat (3) @(negedge clk_sys);
        check("ready during power-up recall", ready, 1'b0);
        check("autostore after reset", auto_on, 1'b1);
        while (ready !== 1'b1 && n < 3000) begin @(negedge clk_sys); n++; end
        check("ready after recall", ready, 1'b1);
        $display("test_powerup done");
    endtask

    task automatic test_rw();
        logic [16:0] a [3] = '{17'h00000, 17'h1FFFF, 17'h04E38};
        logic [7:0]  d [3] = '{8'h5A, 8'hA5, 8'h3C};
        foreach (a[i]) do_op(`NVC_OP_WRITE, a[i], d[i]);
        foreach (a[i]) begin
            do_op(`NVC_OP_READ, a[i], 8'h00);
            check("read back", rd, d[i]);
        end
        $display("test_rw done");
    endtask

    task automatic test_store_recall();
        do_op(`NVC_OP_STORE, 17'h00000, 8'h00);
        check("software store count", d_stores, 1);
        do_op(`NVC_OP_WRITE, 17'h00000, 8'hC3);
        do_op(`NVC_OP_WRITE, 17'h00100, 8'h77);
        do_op(`NVC_OP_RECALL, 17'h00000, 8'h00);
        do_op(`NVC_OP_READ, 17'h00000, 8'h00);
        check("recalled byte", rd, 8'h5A);
        do_op(`NVC_OP_READ, 17'h00100, 8'h00);
        check("cleared byte", rd, 8'h00);
        $display("test_store_recall done");
    endtask

    task automatic test_autostore();
        do_op(`NVC_OP_AUTO_OFF, 17'h00000, 8'h00);
        check("host autostore off", auto_on, 1'b0);
        check("device autostore off", d_auto, 1'b0);
        do_op(`NVC_OP_AUTO_ON, 17'h00000, 8'h00);
        check("host autostore on", auto_on, 1'b1);
        check("device autostore on", d_auto, 1'b1);
        $display("test_autostore done");
    endtask

    task automatic test_pin_store();
        do_op(`NVC_OP_HW_STORE, 17'h00000, 8'h00);
        check("clean pin store skipped", d_stores, 1);
        do_op(`NVC_OP_WRITE, 17'h00200, 8'h99);
        do_op(`NVC_OP_HW_STORE, 17'h00000, 8'h00);
        check("dirty pin store done", d_stores, 2);
        check("busy high drive seen and short", bhi_max > 0 && bhi_max <= 100, 1'b1);
        do_op(`NVC_OP_READ, 17'h00200, 8'h00);
        check("read after pin store", rd, 8'h99);
        $display("test_pin_store done");
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        test_powerup();
        test_rw();
        test_store_recall();
        test_autostore();
        test_pin_store();
        print_verdict();
    end
endmodule
`default_nettype wire
